/* File: hdl/vfmt_regs.sv */
// Format, framing, test and ancillary option registers.
// Assumes host and video events on clk_in; realign pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "vfmt_cfg.svh"
module vfmt_regs #(
    parameter int FIFO_DEPTH = 2048,
    parameter int LVL_W      = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              host_wr_in,
    input  wire logic              host_rd_in,
    input  wire logic [7:0]        host_addr_in,
    input  wire logic [7:0]        host_wdata_in,
    output logic      [7:0]        host_rdata_out,
    output logic                   host_rvalid_out,
    input  wire logic [LVL_W-1:0]  fifo_level_in,
    input  wire logic              anc_hdr_valid_in,
    input  wire vfmt_pkg::anc_hdr_t anc_hdr_in,
    input  wire logic              anc_pkt_done_in,
    output logic                   anc_accept_out,
    output logic                   anc_reject_out,
    input  wire logic              det_valid_in,
    input  wire logic [4:0]        det_code_in,
    output vfmt_pkg::rate_mode_t   rate_mode_out,
    output logic                   forced_active_out,
    input  wire logic              trs_valid_in,
    input  wire vfmt_pkg::trs_evt_t trs_in,
    input  wire logic              realign_pin_in,
    output logic [4:0]             word_boundary_out,
    output logic                   word_locked_out,
    output logic                   mfp_near_full_out,
    output logic                   mfp_short_packet_out,
    output logic                   mfp_misalign_out,
    output logic [5:0]             pattern_select_out,
    output logic                   pattern_gen_on_out,
    output logic                   selftest_usable_out,
    input  wire logic              selftest_done_in,
    input  wire logic              selftest_ok_in
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] fmt_force_q;
    logic [4:0] det_code_q;
    logic       line_blank_q;
    logic       row_blank_q;
    logic       odd_even_q;
    logic [5:0] pat_sel_q;
    logic       pat_gen_on_q;
    logic       st_result_q;
    logic       near_full_q;
    logic       short_pkt_q;
    logic       parity_dis_q;
    logic       vbl_extract_q;
    logic       in_packet_q;
    logic [4:0] boundary_q;
    logic       locked_q;
    logic       misalign_q;
    logic [2:0] realign_sync_q;
    logic       realign_pin_q;

    logic       wr_fmt;
    logic       wr_test;
    logic       wr_anc;
    logic       rd_anc;
    logic       align_mode;
    logic       forced_ok;
    logic       realign_now;
    logic       parity_ok;
    logic       near_full_d;

    assign wr_fmt     = host_wr_in && (host_addr_in == `OFS_FORMAT_FORCE);
    assign wr_test    = host_wr_in && (host_addr_in == `OFS_TEST_PATTERN);
    assign wr_anc     = host_wr_in && (host_addr_in == `OFS_ANC_OPTIONS);
    assign rd_anc     = host_rd_in && (host_addr_in == `OFS_ANC_OPTIONS);
    assign align_mode = fmt_force_q[`BIT_ALIGN_MODE];

    // ------------------------------------------------------------------
    // Raster code table
    // ------------------------------------------------------------------
    function automatic logic code_valid(input logic [4:0] c);
        case (c)
            5'h01, 5'h02, 5'h03, 5'h09, 5'h0a, 5'h0b,
            5'h11, 5'h12, 5'h13, 5'h19, 5'h1a, 5'h1c,
            5'h1d, 5'h14: code_valid = 1'b1; // RL8
            default:      code_valid = 1'b0;
        endcase
    endfunction : code_valid

    function automatic logic id_parity(input logic [9:0] w);
        id_parity = (w[8] == ^w[7:0]) && (w[9] != w[8]);
    endfunction : id_parity

    assign forced_ok = code_valid(fmt_force_q[4:0]);

    // ------------------------------------------------------------------
    // Host writes and reads, 8-bit whole registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fmt_force_q <= `RST_FORMAT_FORCE; // RL16
        end else if (wr_fmt) begin
            fmt_force_q <= host_wdata_in; // RL24
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pat_sel_q    <= 6'(`RST_TEST_PATTERN);
            pat_gen_on_q <= 1'b0;
        end else if (wr_test) begin
            pat_sel_q    <= host_wdata_in[5:0]; // RL23
            pat_gen_on_q <= host_wdata_in[`BIT_PAT_GEN_ON]; // RL21
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            parity_dis_q  <= 1'b0;
            vbl_extract_q <= 1'b0;
        end else if (wr_anc) begin
            parity_dis_q  <= host_wdata_in[`BIT_PARITY_DIS]; // RL3
            vbl_extract_q <= host_wdata_in[`BIT_VBL_EXTRACT]; // RL5
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            host_rdata_out  <= 8'h00;
            host_rvalid_out <= 1'b0;
        end else begin
            host_rvalid_out <= host_rd_in;
            case (host_addr_in)
                `OFS_FORMAT_FORCE: host_rdata_out <= fmt_force_q;
                `OFS_DETECTED:     host_rdata_out <= {odd_even_q, row_blank_q,
                                                      line_blank_q, det_code_q};
                `OFS_TEST_PATTERN: host_rdata_out <= {st_result_q, pat_gen_on_q, pat_sel_q};
                `OFS_ANC_OPTIONS:  host_rdata_out <= {4'h0, vbl_extract_q, parity_dis_q,
                                                      short_pkt_q, near_full_q};
                default:           host_rdata_out <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Ancillary FIFO flags and extraction
    // ------------------------------------------------------------------
    assign near_full_d = (32'(fifo_level_in) * `NEAR_FULL_DEN)
                         >= (32'(FIFO_DEPTH) * `NEAR_FULL_NUM);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            near_full_q       <= 1'b0;
            mfp_near_full_out <= 1'b0;
        end else begin
            near_full_q       <= near_full_d; // RL1
            mfp_near_full_out <= near_full_d; // RL1
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            in_packet_q <= 1'b0;
        end else if (anc_hdr_valid_in) begin
            in_packet_q <= 1'b1;
        end else if (anc_pkt_done_in) begin
            in_packet_q <= 1'b0;
        end
    end

    // Set wins over the read that clears
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            short_pkt_q          <= 1'b0;
            mfp_short_packet_out <= 1'b0;
        end else if (anc_hdr_valid_in && in_packet_q) begin
            short_pkt_q          <= 1'b1; // RL2
            mfp_short_packet_out <= 1'b1; // RL2
        end else if (rd_anc) begin
            short_pkt_q          <= 1'b0;
            mfp_short_packet_out <= 1'b0;
        end
    end

    assign parity_ok = parity_dis_q // RL3
                       || (id_parity(anc_hdr_in.did) && id_parity(anc_hdr_in.sdid)); // RL4

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            anc_accept_out <= 1'b0;
            anc_reject_out <= 1'b0;
        end else begin
            anc_accept_out <= anc_hdr_valid_in && parity_ok
                              && (!anc_hdr_in.vblank || vbl_extract_q); // RL5
            anc_reject_out <= anc_hdr_valid_in && !(parity_ok
                              && (!anc_hdr_in.vblank || vbl_extract_q)); // RL4
        end
    end

    // ------------------------------------------------------------------
    // Format search and detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rate_mode_out     <= vfmt_pkg::SEARCH_BOTH;
            forced_active_out <= 1'b0;
        end else begin
            forced_active_out <= forced_ok; // RL6
            if (forced_ok) begin
                rate_mode_out <= fmt_force_q[`BIT_CODE_HD] ?
                                 vfmt_pkg::SEARCH_HD : vfmt_pkg::SEARCH_SD; // RL7
            end else if (fmt_force_q[`BIT_HD_LOCK]) begin
                rate_mode_out <= vfmt_pkg::SEARCH_HD; // RL9
            end else if (fmt_force_q[`BIT_SD_LOCK]) begin
                rate_mode_out <= vfmt_pkg::SEARCH_SD; // RL10
            end else begin
                rate_mode_out <= vfmt_pkg::SEARCH_BOTH; // RL11
            end
        end
    end

    // Rate variant never reaches the stored code
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            det_code_q <= 5'h00;
        end else if (det_valid_in && code_valid(det_code_in)
                     && (!forced_ok || det_code_in == fmt_force_q[4:0]) // RL6
                     && !(rate_mode_out == vfmt_pkg::SEARCH_HD
                          && !det_code_in[`BIT_CODE_HD])
                     && !(rate_mode_out == vfmt_pkg::SEARCH_SD
                          && det_code_in[`BIT_CODE_HD])) begin
            det_code_q <= det_code_in; // RL17 RL18
        end
    end

    // ------------------------------------------------------------------
    // Word framing and timing reference
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            realign_sync_q <= 3'h0;
            realign_pin_q  <= 1'b0;
        end else begin
            realign_sync_q <= {realign_sync_q[1:0], realign_pin_in};
            if (realign_sync_q[1] == realign_sync_q[2]) begin
                realign_pin_q <= realign_sync_q[2];
            end
        end
    end

    assign realign_now = align_mode ? misalign_q : realign_pin_q; // RL14 RL15

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            boundary_q <= 5'h00;
            locked_q   <= 1'b0;
            misalign_q <= 1'b0;
        end else if (trs_valid_in) begin
            if (!locked_q || realign_now) begin
                boundary_q <= trs_in.offset; // RL12 RL15
                locked_q   <= 1'b1;
                misalign_q <= 1'b0;
            end else begin
                misalign_q <= (trs_in.offset != boundary_q); // RL13
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            word_boundary_out <= 5'h00;
            word_locked_out   <= 1'b0;
            mfp_misalign_out  <= 1'b0;
        end else begin
            word_boundary_out <= boundary_q;
            word_locked_out   <= locked_q;
            mfp_misalign_out  <= misalign_q; // RL14
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            line_blank_q <= 1'b0;
            row_blank_q  <= 1'b0;
            odd_even_q   <= 1'b0;
        end else if (trs_valid_in) begin
            line_blank_q <= trs_in.xyz[`TRS_BIT_H]; // RL19
            row_blank_q  <= trs_in.xyz[`TRS_BIT_V]; // RL19
            odd_even_q   <= trs_in.xyz[`TRS_BIT_F]; // RL19
        end
    end

    // ------------------------------------------------------------------
    // Test pattern and self-test
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pattern_select_out  <= 6'h00;
            pattern_gen_on_out  <= 1'b0;
            selftest_usable_out <= 1'b0;
        end else begin
            pattern_select_out  <= pat_sel_q; // RL20
            pattern_gen_on_out  <= pat_gen_on_q; // RL21
            selftest_usable_out <= (pat_sel_q[`BIT_PAT_HD]
                                    && pat_sel_q[1:0] == `PAT_TYPE_BARS)
                                   || pat_sel_q == `PAT_SD_525_BARS
                                   || pat_sel_q == `PAT_SD_625_PLL; // RL20
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_result_q <= 1'b0;
        end else if (pat_gen_on_q && selftest_done_in) begin
            st_result_q <= selftest_ok_in && selftest_usable_out; // RL22
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_hdr_mid_packet;
        anc_hdr_valid_in && in_packet_q;
    endsequence
    sequence s_off_boundary;
        trs_valid_in && locked_q && !realign_now && trs_in.offset != boundary_q;
    endsequence
    a_short_pkt_set: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL2
        s_hdr_mid_packet |=> short_pkt_q && mfp_short_packet_out)
        else $error("short packet flag not set");
    a_near_full_pin: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL1
        near_full_d |=> mfp_near_full_out)
        else $error("near full pin missed");
    a_parity_block: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL4
        anc_hdr_valid_in && !parity_dis_q && !id_parity(anc_hdr_in.did)
        |=> !anc_accept_out && anc_reject_out)
        else $error("bad parity packet accepted");
    a_vblank_gate: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL5
        anc_hdr_valid_in && anc_hdr_in.vblank && !vbl_extract_q |=> !anc_accept_out)
        else $error("vertical blank packet accepted");
    a_misalign_set: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL13
        s_off_boundary |=> misalign_q ##1 mfp_misalign_out)
        else $error("misalign not flagged");
    a_fixed_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL12
        s_off_boundary |=> $stable(boundary_q))
        else $error("boundary moved in fixed mode");
    a_realign_every: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL15
        trs_valid_in && !align_mode && realign_pin_q
        |=> boundary_q == $past(trs_in.offset) && !misalign_q)
        else $error("no realign on TRS");
    a_rate_auto: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL11
        !forced_ok && !fmt_force_q[`BIT_HD_LOCK] && !fmt_force_q[`BIT_SD_LOCK]
        |=> rate_mode_out == vfmt_pkg::SEARCH_BOTH)
        else $error("auto search not selected");
    a_forced_only: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL6
        det_valid_in && forced_ok && det_code_in != fmt_force_q[4:0] |=> $stable(det_code_q))
        else $error("non forced format stored");
    a_hvf_copy: assert property (@(posedge clk_in) disable iff (!rstn_in) // RL19
        trs_valid_in |=> {odd_even_q, row_blank_q, line_blank_q} == $past(trs_in.xyz[8:6]))
        else $error("H V F not captured");
    a_align_reset: assert property (@(posedge clk_in) // RL16
        !rstn_in |=> align_mode)
        else $error("align mode not one after reset");

endmodule : vfmt_regs
`default_nettype wire

/* File: hdl/vfmt_cfg.svh */
// Offsets, fields, reset values and limits of the format registers.
// Assumes inclusion by bare name wherever used.
//
// Overview of operation
// [RL1] Near-full flag at 90 percent, routed to pin
// [RL2] Header before packet end sets short-packet flag
// [RL3] Parity disable bit skips DID/SDID parity check
// [RL4] Failed DID/SDID parity blocks packet extraction
// [RL5] Vertical blank extract enables packets on blank lines
// [RL6] Forced code restricts processing to one format
// [RL7] Code bit4 HD, bit3 625-family, bits2:0 sub-standard
// [RL8] Fixed raster code assignments for listed formats
// [RL9] HD lock restricts search to HD
// [RL10] SD lock restricts search to SD
// [RL11] Neither lock bit set searches both
// [RL12] Fixed mode aligns once on first TRS
// [RL13] Off-boundary TRS sets misalign, on-boundary clears
// [RL14] Auto mode lets misalign flag drive realign
// [RL15] Realign enable realigns on every valid TRS; the code ignores it in auto mode (align mode one)
// [RL16] Align mode select resets to one
// [RL17] Detected code stored with same assignment
// [RL18] HD rates 74.25 and /1.001 report alike
// [RL19] TRS bits 6,7,8 held as H,V,F
// [RL20] Pattern select chooses output; self-test patterns defined
// [RL21] Pattern generator on enables generator and self-test
// [RL22] Self-test result one is pass
// [RL23] Pattern word: bit5 HD, bit4 scan, bits1:0 type
// [RL24] Registers are 8 bits, whole-word access
`ifndef VFMT_CFG_SVH
`define VFMT_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_FORMAT_FORCE  8'h0b
`define OFS_DETECTED      8'h0c
`define OFS_TEST_PATTERN  8'h0d
`define OFS_ANC_OPTIONS   8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_HD_LOCK       5
`define BIT_SD_LOCK       6
`define BIT_ALIGN_MODE    7
`define BIT_CODE_HD       4
`define BIT_CODE_625      3
`define BIT_PAT_HD        5
`define BIT_PAT_GEN_ON    6
`define BIT_ST_RESULT     7
`define BIT_NEAR_FULL     0
`define BIT_SHORT_PKT     1
`define BIT_PARITY_DIS    2
`define BIT_VBL_EXTRACT   3
`define TRS_BIT_H         6
`define TRS_BIT_V         7
`define TRS_BIT_F         8

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define RST_FORMAT_FORCE  8'h80
`define RST_TEST_PATTERN  8'h00
`define RST_ANC_OPTIONS   8'h00
`define NEAR_FULL_NUM     9
`define NEAR_FULL_DEN     10
`define PAT_TYPE_BARS     2'h3
`define PAT_TYPE_PLL      2'h1
`define PAT_SD_525_BARS   6'h03
`define PAT_SD_625_PLL    6'h11

`endif

/* File: hdl/vfmt_pkg.sv */
// Types shared by the format and framing register block.
// Assumes vfmt_cfg.svh is on the include path.
`include "vfmt_cfg.svh"
package vfmt_pkg;

    typedef enum logic [1:0] {
        SEARCH_BOTH,
        SEARCH_HD,
        SEARCH_SD
    } rate_mode_t;

    typedef struct packed {
        logic [9:0] did;
        logic [9:0] sdid;
        logic       vblank;
    } anc_hdr_t;

    typedef struct packed {
        logic [4:0] offset;
        logic [9:0] xyz;
    } trs_evt_t;

endpackage : vfmt_pkg

/* File: tb/host_port_model.sv */
// Host model: whole-word register reads and writes.
// Assumes strobes are sampled on the rising clk_in edge.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out
);
    initial begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end

    // ------------------------------------------------------------------
    // Bus cycles, one whole 8-bit word each
    // ------------------------------------------------------------------
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out    <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_in);
        rd_out   <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        v = rvalid_in;
        d = rdata_in;
    endtask : read_reg

    // Partial field change by read-modify-write
    task automatic modify_reg(input logic [7:0] a, input logic [7:0] s, input logic [7:0] c);
        logic [7:0] d;
        logic       v;
        read_reg(a, d, v);
        write_reg(a, (d & ~c) | s);
    endtask : modify_reg
endmodule : host_port_model
`default_nettype wire

/* File: tb/tb_vfmt_regs.sv */
// Self-checking bench for the format register block.
// Assumes host_port_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "vfmt_cfg.svh"
module tb_vfmt_regs;
    logic                 clk_in, rstn_in, wr, rd, rv, hv, done, dv, tv, pin, sd, sok;
    logic                 acc, rej, fa, lk, nf, sp, mis, pg, su;
    logic [7:0]           a, wd, rdat;
    logic [4:0]           wb, dc;
    logic [5:0]           ps;
    logic [11:0]          lvl;
    vfmt_pkg::rate_mode_t rm;
    vfmt_pkg::anc_hdr_t   hdr;
    vfmt_pkg::trs_evt_t   trs;
    int                   errors, comparisons;

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    vfmt_regs #(.FIFO_DEPTH(100), .LVL_W(12)) vfmt_regs_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .host_wr_in(wr), .host_rd_in(rd),
        .host_addr_in(a), .host_wdata_in(wd), .host_rdata_out(rdat), .host_rvalid_out(rv),
        .fifo_level_in(lvl), .anc_hdr_valid_in(hv), .anc_hdr_in(hdr), .anc_pkt_done_in(done),
        .anc_accept_out(acc), .anc_reject_out(rej), .det_valid_in(dv), .det_code_in(dc),
        .rate_mode_out(rm), .forced_active_out(fa), .trs_valid_in(tv), .trs_in(trs),
        .realign_pin_in(pin), .word_boundary_out(wb), .word_locked_out(lk),
        .mfp_near_full_out(nf), .mfp_short_packet_out(sp), .mfp_misalign_out(mis),
        .pattern_select_out(ps), .pattern_gen_on_out(pg), .selftest_usable_out(su),
        .selftest_done_in(sd), .selftest_ok_in(sok));

    host_port_model host_port_model_i (.clk_in(clk_in), .rdata_in(rdat), .rvalid_in(rv),
        .wr_out(wr), .rd_out(rd), .addr_out(a), .wdata_out(wd));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
        host_port_model_i.write_reg(ad, d);
        tick(2);
    endtask : wr8
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        host_port_model_i.read_reg(ad, d, v);
        chk("read valid", 8'h01, {7'h0, v});
        chk("read data", e, d);
    endtask : rchk
    function automatic logic [9:0] id10(input logic [7:0] b, input logic bad);
        return {~(^b ^ bad), ^b ^ bad, b};
    endfunction : id10
    task automatic anc(input logic bad, input logic vb, input logic ea, input logic fin);
        @(posedge clk_in);
        hv  <= 1'b1;
        hdr <= '{did: id10(8'h41, bad), sdid: id10(8'h05, 1'b0), vblank: vb};
        @(posedge clk_in);
        hv  <= 1'b0;
        #1;
        chk("accept", {7'h0, ea}, {7'h0, acc});
        chk("reject", {7'h0, ~ea}, {7'h0, rej});
        if (fin) begin
            @(posedge clk_in);
            done <= 1'b1;
            @(posedge clk_in);
            done <= 1'b0;
        end
    endtask : anc
    task automatic trs_ev(input logic [4:0] off);
        @(posedge clk_in);
        tv  <= 1'b1;
        trs <= '{offset: off, xyz: 10'h3b0};
        @(posedge clk_in);
        tv  <= 1'b0;
        tick(3);
    endtask : trs_ev
    task automatic det(input logic [4:0] c, input logic [7:0] e);
        @(posedge clk_in);
        dv <= 1'b1;
        dc <= c;
        @(posedge clk_in);
        dv <= 1'b0;
        tick(2);
        rchk(`OFS_DETECTED, e);
    endtask : det
    task automatic st(input logic ok);
        @(posedge clk_in);
        sd  <= 1'b1;
        sok <= ok;
        @(posedge clk_in);
        sd <= 1'b0;
        tick(2);
    endtask : st

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rchk(`OFS_FORMAT_FORCE, 8'h80);
        rchk(`OFS_TEST_PATTERN, 8'h00);
        rchk(`OFS_ANC_OPTIONS, 8'h00);
        rchk(8'h3f, 8'h00);
        chk("rate", {6'h0, vfmt_pkg::SEARCH_BOTH}, {6'h0, rm});
    endtask : t_reset
    task automatic t_align();
        wr8(`OFS_FORMAT_FORCE, 8'h00);
        trs_ev(5'd3);
        chk("boundary", 8'h03, {3'h0, wb});
        chk("locked", 8'h01, {7'h0, lk});
        trs_ev(5'd5);
        chk("boundary", 8'h03, {3'h0, wb});
        chk("misalign", 8'h01, {7'h0, mis});
        rchk(`OFS_DETECTED, 8'hc0);
        trs_ev(5'd3);
        chk("misalign", 8'h00, {7'h0, mis});
        pin <= 1'b1;
        tick(5);
        trs_ev(5'd7);
        chk("boundary", 8'h07, {3'h0, wb});
        trs_ev(5'd9);
        chk("boundary", 8'h09, {3'h0, wb});
        pin <= 1'b0;
        tick(5);
        trs_ev(5'd9);
        wr8(`OFS_FORMAT_FORCE, 8'h80);
        trs_ev(5'd12);
        chk("boundary", 8'h09, {3'h0, wb});
        chk("misalign", 8'h01, {7'h0, mis});
        trs_ev(5'd12);
        chk("boundary", 8'h0c, {3'h0, wb});
    endtask : t_align
    task automatic t_format();
        host_port_model_i.modify_reg(`OFS_FORMAT_FORCE, 8'h20, 8'h40);
        tick(2);
        chk("rate", {6'h0, vfmt_pkg::SEARCH_HD}, {6'h0, rm});
        det(5'h03, 8'hc0);
        det(5'h13, 8'hd3);
        host_port_model_i.modify_reg(`OFS_FORMAT_FORCE, 8'h40, 8'h20);
        tick(2);
        chk("rate", {6'h0, vfmt_pkg::SEARCH_SD}, {6'h0, rm});
        det(5'h14, 8'hd3);
        det(5'h0b, 8'hcb);
        wr8(`OFS_FORMAT_FORCE, 8'h93);
        chk("forced", 8'h01, {7'h0, fa});
        det(5'h14, 8'hcb);
        det(5'h13, 8'hd3);
        wr8(`OFS_FORMAT_FORCE, 8'h9f);
        chk("forced", 8'h00, {7'h0, fa});
        chk("rate", {6'h0, vfmt_pkg::SEARCH_BOTH}, {6'h0, rm});
        det(5'h1d, 8'hdd);
        wr8(`OFS_DETECTED, 8'hff);
        rchk(`OFS_DETECTED, 8'hdd);
    endtask : t_format
    task automatic t_anc();
        @(posedge clk_in);
        lvl <= 12'd89;
        tick(2);
        chk("near full", 8'h00, {7'h0, nf});
        lvl <= 12'd90;
        tick(2);
        chk("near full", 8'h01, {7'h0, nf});
        rchk(`OFS_ANC_OPTIONS, 8'h01);
        lvl <= 12'd0;
        anc(1'b0, 1'b0, 1'b1, 1'b0);
        anc(1'b0, 1'b0, 1'b1, 1'b1);
        tick(2);
        chk("short pin", 8'h01, {7'h0, sp});
        rchk(`OFS_ANC_OPTIONS, 8'h02);
        rchk(`OFS_ANC_OPTIONS, 8'h00);
        anc(1'b1, 1'b0, 1'b0, 1'b1);
        wr8(`OFS_ANC_OPTIONS, 8'hff);
        rchk(`OFS_ANC_OPTIONS, 8'h0c);
        anc(1'b1, 1'b1, 1'b1, 1'b1);
        wr8(`OFS_ANC_OPTIONS, 8'h00);
        anc(1'b0, 1'b1, 1'b0, 1'b1);
    endtask : t_anc
    task automatic t_pattern();
        logic [6:0] tbl [8] = '{7'h47, 7'h67, 7'h7f, 7'h07, 7'h23, 7'h44, 7'h26, 7'h02};
        wr8(`OFS_TEST_PATTERN, 8'h43);
        chk("pattern", 8'h03, {2'h0, ps});
        chk("gen on", 8'h01, {7'h0, pg});
        st(1'b1);
        rchk(`OFS_TEST_PATTERN, 8'hc3);
        st(1'b0);
        rchk(`OFS_TEST_PATTERN, 8'h43);
        wr8(`OFS_TEST_PATTERN, 8'hc0);
        st(1'b1);
        rchk(`OFS_TEST_PATTERN, 8'h40);
        foreach (tbl[i]) begin
            wr8(`OFS_TEST_PATTERN, {2'b01, tbl[i][6:1]});
            chk("usable", {7'h0, tbl[i][0]}, {7'h0, su});
        end
        wr8(`OFS_TEST_PATTERN, 8'h03);
        chk("gen on", 8'h00, {7'h0, pg});
    endtask : t_pattern

    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        complete_run();
    end

    initial begin
        errors      = 0;
        comparisons = 0;
        rstn_in     = 1'b0;
        {hv, done, dv, tv, pin, sd, sok} = 7'h00;
        hdr = '0;
        trs = '0;
        dc  = 5'h00;
        lvl = 12'h000;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_align();
        t_format();
        t_anc();
        t_pattern();
        complete_run();
    end
endmodule : tb_vfmt_regs
`default_nettype wire
